//--- include/config_prom_regs.svh
// Constants for the configuration memory pin-control block
// Function
// (R1) Loading mode: data driver on only while chip select and output enable are low; code takes OE as active at the reset_polarity level.
// (R2) Loading mode: chip select high stops counters and enters low power.
// (R3) Programming mode: chip select does not enable or disable the two-wire bus.
// (R4) Polarity-capable variants: chip select low in programming targets the main array.
// (R5) Chip select high in programming deselects array; write sets reset polarity.
// (R6) Cascade output goes low the cycle after the last bit is read.
// (R7) Cascade low while both enables low, then follows chip select until OE high.
// (R8) After output enable rises, cascade stays high until memory is read again.
// (R9) System drives the device-select strap to a defined level in programming.
// (R10) Programming: respond only when address select bit equals the strap.
// (R11) Ready output held low during power-up reset, released afterwards.
// (R12) Serial-enable high selects loading mode, low selects programming mode.
// (R13) Two write-protect inputs together select which blocks reject writes.
// (R14) Loading mode: counter reset level clears address and bit counters.
// (R15) Protected block addressed: each data byte is acknowledged but not stored.
`ifndef CONFIG_PROM_REGS_SVH
`define CONFIG_PROM_REGS_SVH

`define ADDR_W          17
`define BIT_W           3
`define LAST_ADDR       17'h1ffff
`define SEL_BIT_POS     2
`define POR_NS          1000
`define CLK_NS          10
`define POR_CYCLES      ((`POR_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_POL_RESET   1'b0

`endif

//--- include/config_prom_pkg.sv
// Types for the configuration memory pin-control block
package config_prom_pkg;
  typedef enum logic [2:0] {
    CASC_IDLE = 3'b001,
    CASC_DONE = 3'b010,
    CASC_HOLD = 3'b100
  } casc_state_t;
endpackage

//--- hdl/protect_decode.sv
// Block write-protect decode from the two protect inputs
`timescale 1ns/1ps
`include "config_prom_regs.svh"
module protect_decode (
  input  wire logic [1:0]         protect_pins,
  input  wire logic [`ADDR_W-1:0] addr,
  output logic                    blocked
);
  // Both inputs pick how many top quarters reject writes
  always_comb begin
    unique case (protect_pins) // [R13]
      2'b00:   blocked = 1'b0;
      2'b01:   blocked = (addr[`ADDR_W-1:`ADDR_W-2] == 2'b11);
      2'b10:   blocked = addr[`ADDR_W-1];
      2'b11:   blocked = 1'b1;
    endcase
  end
endmodule // protect_decode

//--- hdl/config_prom_pin_control.sv
// Pin-level control of a serial configuration memory
`timescale 1ns/1ps
`include "config_prom_regs.svh"
module config_prom_pin_control (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               program_mode_select_n,
  input  wire logic               chip_select_n,
  input  wire logic               reset_oe,
  input  wire logic               block_protect_a,
  input  wire logic               block_protect_b,
  input  wire logic               device_select_strap,
  input  wire logic               addr_select_bit,
  input  wire logic               addr_valid,
  input  wire logic               prog_write,
  input  wire logic [`ADDR_W-1:0] prog_addr,
  input  wire logic               has_polarity_ctrl,
  output logic                    data_oe,
  output logic                    low_power,
  output logic [`ADDR_W-1:0]      read_addr,
  output logic [`BIT_W-1:0]       bit_index,
  output logic                    cascade_enable_out_n,
  output logic                    ready_o,
  output logic                    ready_oe,
  output logic                    device_selected,
  output logic                    array_select,
  output logic                    array_write,
  output logic                    write_ack,
  output logic                    reset_polarity
);
  logic                    rst_s1_r;
  logic                    rst_n_r;
  logic [15:0]             por_cnt_r;
  logic                    por_done_r;
  logic                    load_mode;
  logic                    oe_active;
  logic                    ctr_clear;
  logic [`ADDR_W-1:0]      addr_r;
  logic [`BIT_W-1:0]       bit_r;
  logic                    last_bit;
  logic                    sel_r;
  logic                    blocked;
  logic                    pol_r;
  config_prom_pkg::casc_state_t casc_r;
  config_prom_pkg::casc_state_t casc_nxt;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Power-up reset timer
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      por_cnt_r  <= 16'h0000;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 16'h0001;
      por_done_r <= (por_cnt_r == 16'(`POR_CYCLES - 1));
    end
  end

  // Open-drain ready: driven low until power-up reset clears
  assign ready_o  = 1'b0;
  assign ready_oe = !por_done_r; // [R11]

  // Mode selection and reset/OE polarity
  assign load_mode = program_mode_select_n; // [R12]
  assign oe_active = (reset_oe ^ pol_r) == 1'b0;
  assign ctr_clear = load_mode && !oe_active; // [R14]
  assign data_oe   = load_mode && !chip_select_n && oe_active && por_done_r; // [R1]
  assign low_power = load_mode && chip_select_n; // [R2]
  assign last_bit  = (addr_r == `LAST_ADDR) && (bit_r == {`BIT_W{1'b1}});

  // Address and bit counters for loading
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_r <= '0;
      bit_r  <= '0;
    end else if (ctr_clear) begin
      addr_r <= '0; // [R14]
      bit_r  <= '0;
    end else if (load_mode && !chip_select_n && por_done_r) begin // [R2]
      bit_r <= bit_r + 1'b1;
      if (bit_r == {`BIT_W{1'b1}})
        addr_r <= (addr_r == `LAST_ADDR) ? '0 : addr_r + 1'b1;
    end
  end
  assign read_addr = addr_r;
  assign bit_index = bit_r;

  // Cascade enable state
  always_comb begin
    casc_nxt = casc_r;
    unique case (casc_r)
      config_prom_pkg::CASC_IDLE:
        if (load_mode && !chip_select_n && last_bit && !ctr_clear)
          casc_nxt = config_prom_pkg::CASC_DONE; // [R6]
      config_prom_pkg::CASC_DONE:
        if (!oe_active)
          casc_nxt = config_prom_pkg::CASC_HOLD; // [R7]
      config_prom_pkg::CASC_HOLD:
        if (load_mode && !chip_select_n && last_bit && !ctr_clear)
          casc_nxt = config_prom_pkg::CASC_DONE; // [R8]
      default: casc_nxt = config_prom_pkg::CASC_IDLE;
    endcase
    if (!load_mode)
      casc_nxt = config_prom_pkg::CASC_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) casc_r <= config_prom_pkg::CASC_IDLE;
    else          casc_r <= casc_nxt;
  end

  // Low on entering done; follows chip select while done; high otherwise
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r)
      cascade_enable_out_n <= 1'b1;
    else if (casc_nxt == config_prom_pkg::CASC_DONE)
      cascade_enable_out_n <= (casc_r == config_prom_pkg::CASC_DONE) ?
                              chip_select_n : 1'b0; // [R6] [R7]
    else
      cascade_enable_out_n <= 1'b1; // [R8]
  end

  // Strap match on the received device address
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r)
      sel_r <= 1'b0;
    else if (load_mode)
      sel_r <= 1'b0;
    else if (addr_valid)
      sel_r <= (addr_select_bit == device_select_strap); // [R10] [R9] [R3]
  end
  assign device_selected = sel_r;

  protect_decode u_protect (
    .protect_pins ({block_protect_b, block_protect_a}),
    .addr         (prog_addr),
    .blocked      (blocked)
  );

  // Array target and polarity writes in programming
  assign array_select = sel_r && !load_mode &&
                        (!has_polarity_ctrl || !chip_select_n); // [R4]
  assign array_write  = array_select && prog_write && !blocked; // [R13] [R15]
  assign write_ack    = sel_r && !load_mode && prog_write; // [R15]

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r)
      pol_r <= `RST_POL_RESET;
    else if (sel_r && !load_mode && has_polarity_ctrl && chip_select_n && prog_write)
      pol_r <= !pol_r; // [R5]
  end
  assign reset_polarity = pol_r;
endmodule // config_prom_pin_control

//--- tb/config_prom_pin_control_chk.sv
// Port assertions for the memory pin control
`timescale 1ns/1ps
`include "config_prom_regs.svh"
module config_prom_pin_control_chk (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               program_mode_select_n,
  input wire logic               chip_select_n,
  input wire logic               reset_oe,
  input wire logic               prog_write,
  input wire logic               addr_valid,
  input wire logic               addr_select_bit,
  input wire logic               device_select_strap,
  input wire logic               data_oe,
  input wire logic               low_power,
  input wire logic [`BIT_W-1:0]  bit_index,
  input wire logic               cascade_enable_out_n,
  input wire logic               ready_o,
  input wire logic               ready_oe,
  input wire logic               device_selected,
  input wire logic               write_ack,
  input wire logic               reset_polarity
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pin relations
  a_drv_gate: assert property (data_oe |-> program_mode_select_n && !chip_select_n)
    else $error("data driver on without enables");
  a_cs_idle: assert property (program_mode_select_n && chip_select_n |->
    low_power && !data_oe ##1
    (bit_index == $past(bit_index) || $past(reset_oe) != $past(reset_polarity)))
    else $error("chip select high did not idle");
  a_prog_quiet: assert property (!program_mode_select_n |-> !data_oe && !low_power)
    else $error("programming mode drove loading pins");
  a_ready_low: assert property (ready_oe |-> !ready_o && !data_oe)
    else $error("ready released during power-up");
  a_sel_match: assert property (!program_mode_select_n && addr_valid |=>
    device_selected == ($past(addr_select_bit) == $past(device_select_strap)))
    else $error("select does not follow strap");
  a_ack_byte: assert property (!program_mode_select_n && !chip_select_n &&
    device_selected && prog_write |-> write_ack)
    else $error("data byte not acknowledged");
  a_casc_hold: assert property (!cascade_enable_out_n && program_mode_select_n &&
    !chip_select_n && reset_oe == reset_polarity |=> !cascade_enable_out_n)
    else $error("cascade output rose early");
  a_mode_pick: assert property (program_mode_select_n && !chip_select_n &&
    reset_oe == reset_polarity && !ready_oe |-> data_oe)
    else $error("loading mode not entered");
endmodule // config_prom_pin_control_chk
bind config_prom_pin_control config_prom_pin_control_chk config_prom_pin_control_chk_i (.*);

//--- tb/prog_host_model.sv
// Programmer model sending a device address then one byte
`timescale 1ns/1ps
module prog_host_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic sel,
  input  wire logic strap,
  output logic      addr_valid,
  output logic      addr_select_bit,
  output logic      prog_write,
  output logic      device_select_strap
);
  logic step_r = 1'b0;
  initial {addr_valid, addr_select_bit, prog_write} = 3'h0;
  // Strap always at a defined level
  assign device_select_strap = strap;
  // Address pulse, then one data byte two cycles on
  always @(posedge clk) begin
    addr_valid <= go;
    addr_select_bit <= go ? sel : ~addr_select_bit;
    step_r <= addr_valid;
    prog_write <= step_r;
  end
endmodule // prog_host_model

//--- tb/config_prom_pin_control_test.sv
// Self-checking bench for the memory pin control
`timescale 1ns/1ps
`include "config_prom_regs.svh"
module config_prom_pin_control_test;
  logic clk = 0, reset_n = 0, program_mode_select_n = 1, chip_select_n = 1, reset_oe = 1;
  logic block_protect_a = 0, block_protect_b = 0, has_polarity_ctrl = 0, go = 0, sel = 0;
  logic strap = 0, device_select_strap, addr_select_bit, addr_valid, prog_write;
  logic [`ADDR_W-1:0] prog_addr = 17'h0, read_addr;
  logic [`BIT_W-1:0]  bit_index;
  logic data_oe, low_power, cascade_enable_out_n, ready_o, ready_oe, device_selected;
  logic array_select, array_write, write_ack, reset_polarity;
  int   n_errors = 0, num_checks = 0, n;
  config_prom_pin_control config_prom_pin_control_i (.*);
  prog_host_model prog_host_model_i (.clk(clk), .go(go), .sel(sel), .strap(strap),
    .addr_valid(addr_valid), .addr_select_bit(addr_select_bit), .prog_write(prog_write),
    .device_select_strap(device_select_strap));
  always #5 clk = ~clk;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Protected range from the two protect pins
  function automatic logic prot(input logic [16:0] a);
    logic [1:0] p;
    p = {block_protect_b, block_protect_a};
    return p == 2'h3 || (p == 2'h2 && a[16]) || (p == 2'h1 && a[16:15] == 2'h3);
  endfunction
  task final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #50us n_errors++;
    final_report;
  end
  // Main sequence
  initial begin
    void'($urandom(90184));
    repeat (4) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    #1 chk(ready_oe, 1);
    repeat (110) @(posedge clk);
    #1 chk(ready_oe, 0);
    chk(ready_o, 0);
    for (int k = 0; k < 2; k++) begin
      n = 9 + $urandom % 200;
      @(posedge clk) {chip_select_n, reset_oe} <= 2'h1;
      @(posedge clk) {chip_select_n, reset_oe} <= 2'h0;
      repeat (n) @(posedge clk);
      #1 chk(bit_index, 17'(n % 8));
      chk(read_addr, 17'(n / 8));
      chk(data_oe, 1);
      chk(cascade_enable_out_n, 1);
      @(posedge clk) if (k) reset_oe <= 1; else chip_select_n <= 1;
      @(posedge clk) #1 chk(read_addr, k ? 17'h0 : 17'((n + 1) / 8));
      chk(bit_index, k ? 17'h0 : 17'((n + 1) % 8));
      chk(low_power, !k);
      chk(data_oe, 0);
    end
    $display("loading tests done");
    @(posedge clk) program_mode_select_n <= 0;
    repeat (20) begin
      @(posedge clk) {go, sel, strap, chip_select_n} <= {1'b1, 3'($urandom)};
      {block_protect_b, block_protect_a} <= 2'($urandom);
      prog_addr <= 17'($urandom);
      @(posedge clk) go <= 0;
      repeat (2) @(posedge clk);
      #1 chk(device_selected, sel == strap);
      chk(write_ack, sel == strap);
      chk(array_write, sel == strap && !prot(prog_addr));
    end
    @(posedge clk) {has_polarity_ctrl, chip_select_n, go, sel, strap} <= 5'h1c;
    @(posedge clk) go <= 0;
    repeat (3) @(posedge clk);
    #1 chk(reset_polarity, 1);
    chk(array_select, 0);
    @(posedge clk) chip_select_n <= 0;
    @(posedge clk) #1 chk(array_select, 1);
    // Back to loading: high reset_oe now enables, low clears
    @(posedge clk) {program_mode_select_n, chip_select_n, reset_oe} <= 3'h5;
    @(posedge clk) #1 chk(data_oe, 1);
    chk(bit_index, 1);
    @(posedge clk) reset_oe <= 0;
    @(posedge clk) #1 chk(bit_index, 0);
    chk(data_oe, 0);
    $display("programming tests done");
    final_report;
  end
endmodule // config_prom_pin_control_test
